// File: pic_core.sv
// Peripheral interrupt flags, core interrupt controller and dispatch
`timescale 1ns/1ps
module pic_core
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   // Core sequencer
   input  wire logic              core_ack_i,
   input  wire logic              core_return_i,
   output logic                   core_irq_req_o,
   output logic      [ADDR_W-1:0] core_vector_o,
   output logic                   shared_periph_request_n_o,
   // Event sources
   input  wire logic              timer_expire_i,
   input  wire logic              serial_rx_request_n_i,
   input  wire logic              serial_tx_request_n_i,
   input  wire logic              pwm_period_sync_pulse_i,
   input  wire logic              pwm_shutdown_n_i,
   input  wire logic [NGPIO-1:0]  gpio_line_i,
   input  wire logic [NGPIO-1:0]  gpio_select_i,
   input  wire logic [NGPIO-1:0]  gpio_dir_out_i
);

   logic [9:0]       interrupt_mask_reg;
   logic [4:0]       interrupt_sense_nesting_control;
   logic [NGPIO-1:0] gpio_irq_en;
   logic [NGPIO-1:0] gpio_flag;
   logic             sync_flag;
   logic             trip_flag;
   logic             sync_prev;
   logic             trip_prev;
   logic             rx_prev;
   logic             tx_prev;
   logic             periph_prev;
   logic [NGPIO-1:0] gpio_prev;
   logic [NCORE-1:0] latched;
   logic [NCORE-1:0] in_service;
   logic [2:0]       req_idx;

   logic             wr_force;
   logic             wr_swt;
   logic             rd_st;
   logic             rd_glo;
   logic             rd_g9;
   logic [NGPIO-1:0] gpio_set;
   logic [NCORE-1:0] edge_set;
   logic [NCORE-1:0] level_act;
   logic [NCORE-1:0] pend;
   logic [NCORE-1:0] mask_vec;
   logic [NCORE-1:0] cand;
   logic [NCORE-1:0] ack_clr;
   logic [NCORE-1:0] ret_clr;
   logic [2:0]       top_cand;
   logic [2:0]       top_serv;
   logic             allow;
   logic             next_req;
   logic [13:0]      next_vector;
   logic             periph_n;

   // Highest set bit; 7 when none is set
   function automatic logic [2:0] top_of(input logic [NCORE-1:0] v);
      logic [2:0] r;
      r = 3'h7;
      for (int i = 0; i < NCORE; i++) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   assign wr_force = reg_wr_i && (reg_addr_i == FORCE_OFS);
   assign wr_swt = reg_wr_i && (reg_addr_i == SW_SHUTDOWN_OFS);
   assign rd_st  = reg_rd_i && (reg_addr_i == SYNC_TRIP_FLAG_OFS);
   assign rd_glo = reg_rd_i && (reg_addr_i == GPIO_LOW_FLAG_OFS);
   assign rd_g9  = reg_rd_i && (reg_addr_i == GPIO_NINTH_FLAG_OFS);

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         interrupt_mask_reg              <= MASK_RST;
         interrupt_sense_nesting_control <= SENSE_RST;
         gpio_irq_en                     <= GPIO_EN_RST;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            MASK_OFS: interrupt_mask_reg <= reg_wdata_i[9:0];
            SENSE_OFS: interrupt_sense_nesting_control <= reg_wdata_i[4:0];
            GPIO_LOW_EN_OFS: gpio_irq_en[7:0] <= reg_wdata_i[7:0];
            GPIO_NINTH_EN_OFS: gpio_irq_en[8] <= reg_wdata_i[0];
            default: ;
         endcase
      end
   end

   // Edge history; GPIO lines idle low through their pull-downs
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_prev   <= 1'b0;
         trip_prev   <= 1'b1;
         rx_prev     <= 1'b1;
         tx_prev     <= 1'b1;
         periph_prev <= 1'b1;
         gpio_prev   <= '0;
      end else begin
         sync_prev   <= pwm_period_sync_pulse_i;
         trip_prev   <= pwm_shutdown_n_i;
         rx_prev     <= serial_rx_request_n_i;
         tx_prev     <= serial_tx_request_n_i;
         periph_prev <= periph_n;
         gpio_prev   <= gpio_line_i;
      end
   end

   assign gpio_set = gpio_select_i & ~gpio_dir_out_i & gpio_irq_en &
                     (gpio_line_i ^ gpio_prev);

   // flags latch events; set wins over read clear
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_flag <= 1'b0;
         trip_flag <= 1'b0;
         gpio_flag <= '0;
      end else begin
         sync_flag <= (sync_flag && !rd_st) ||
                      (pwm_period_sync_pulse_i && !sync_prev);
         trip_flag <= (trip_flag && !rd_st) ||
                      (!pwm_shutdown_n_i && trip_prev) || wr_swt;
         gpio_flag[7:0] <= (gpio_flag[7:0] & ~{8{rd_glo}}) | gpio_set[7:0];
         gpio_flag[8]   <= (gpio_flag[8] && !rd_g9) || gpio_set[8];
      end
   end

   // held low while any flag stands
   // sync, trip and GPIO flags merged onto one line; timer and serial stay separate
   assign periph_n = !(sync_flag || trip_flag || (|gpio_flag));
   assign shared_periph_request_n_o = periph_n;

   // edge or level per control bit
   // level on the shared line keeps no event lost
   always_comb begin
      edge_set = '0;
      edge_set[SRC_TIMER] = timer_expire_i;
      edge_set[SRC_RX] = interrupt_sense_nesting_control[SENSE_RX_EDGE] &&
                         !serial_rx_request_n_i && rx_prev;
      edge_set[SRC_TX] = interrupt_sense_nesting_control[SENSE_TX_EDGE] &&
                         !serial_tx_request_n_i && tx_prev;
      edge_set[SRC_PERIPH] =
         interrupt_sense_nesting_control[SENSE_PERIPH_EDGE] &&
         !periph_n && periph_prev;
      level_act = '0;
      level_act[SRC_RX] = !interrupt_sense_nesting_control[SENSE_RX_EDGE] &&
                          !serial_rx_request_n_i;
      level_act[SRC_TX] = !interrupt_sense_nesting_control[SENSE_TX_EDGE] &&
                          !serial_tx_request_n_i;
      level_act[SRC_PERIPH] =
         !interrupt_sense_nesting_control[SENSE_PERIPH_EDGE] && !periph_n;
   end

   assign ack_clr = (core_ack_i && core_irq_req_o) ?
                    NCORE'(1 << req_idx) : '0;
   assign ret_clr = (core_return_i && top_serv != 3'h7) ?
                    NCORE'(1 << top_serv) : '0;

   // low byte clears, high byte forces; force wins
   // software bits set only by force bits 11 and 12
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         latched <= '0;
      end else begin
         latched <= (latched & ~ack_clr &
                     ~(wr_force ? reg_wdata_i[NCORE-1:0] : '0)) |
                    edge_set |
                    (wr_force ? reg_wdata_i[FORCE_BASE +: NCORE] : '0);
      end
   end

   // bit 9 gates the shared request
   assign mask_vec = {interrupt_mask_reg[MASK_PERIPH_BIT],
                      interrupt_mask_reg[NCORE-2:0]};
   assign pend     = latched | level_act;
   assign cand     = pend & mask_vec;
   assign top_cand = top_of(cand);
   assign top_serv = top_of(in_service);

   // nesting only with bit 4 set, and only above current
   always_comb begin
      if (in_service == '0) begin
         allow = 1'b1;
      end else begin
         allow = interrupt_sense_nesting_control[SENSE_NEST] &&
                 (top_cand > top_serv);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_service <= '0;
      end else begin
         in_service <= (in_service & ~ret_clr) | ack_clr;
      end
   end

   // fixed vectors; peripheral sub-order trip, sync, GPIO
   // each vector is a four-word slot base
   always_comb begin
      unique case (top_cand)
         3'(SRC_PERIPH): begin
            if (trip_flag) begin
               next_vector = VEC_TRIP;
            end else if (sync_flag) begin
               next_vector = VEC_SYNC;
            end else if (|gpio_flag) begin
               next_vector = VEC_GPIO;
            end else begin
               next_vector = VEC_PERIPH;
            end
         end
         3'(SRC_SW1):   next_vector = VEC_SW1;
         3'(SRC_SW0):   next_vector = VEC_SW0;
         3'(SRC_TX):    next_vector = VEC_TX;
         3'(SRC_RX):    next_vector = VEC_RX;
         3'(SRC_TIMER): next_vector = VEC_TIMER;
         default:       next_vector = '0;
      endcase
   end

   // One cycle gap after an ack so a stale request is never taken twice
   assign next_req = (top_cand != 3'h7) && allow && !ack_clr[0] &&
                     !(core_ack_i && core_irq_req_o);

   // vector presented directly, one register stage only
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_irq_req_o <= 1'b0;
         core_vector_o  <= '0;
         req_idx        <= 3'h7;
      end else begin
         core_irq_req_o <= next_req;
         core_vector_o  <= next_vector;
         req_idx        <= top_cand;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            MASK_OFS:    reg_rdata_o <= {6'h00, interrupt_mask_reg};
            SENSE_OFS:
               reg_rdata_o <= {11'h000, interrupt_sense_nesting_control};
            CORE_STAT_OFS:
               reg_rdata_o <= {2'h0, in_service, 2'h0, pend};
            GPIO_LOW_EN_OFS:    reg_rdata_o <= {8'h00, gpio_irq_en[7:0]};
            GPIO_NINTH_EN_OFS:  reg_rdata_o <= {15'h0000, gpio_irq_en[8]};
            GPIO_LOW_FLAG_OFS:  reg_rdata_o <= {8'h00, gpio_flag[7:0]};
            GPIO_NINTH_FLAG_OFS: reg_rdata_o <= {15'h0000, gpio_flag[8]};
            SYNC_TRIP_FLAG_OFS: begin
               reg_rdata_o <= '0;
               reg_rdata_o[SYNC_FLAG_BIT] <= sync_flag;
               reg_rdata_o[TRIP_FLAG_BIT] <= trip_flag;
            end
            default: reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sync_rise_a: assert property (
      $rose(pwm_period_sync_pulse_i) |=> sync_flag)
      else $error("sync edge not flagged");
   trip_pin_a: assert property (
      ($fell(pwm_shutdown_n_i) || wr_swt) |=> trip_flag)
      else $error("trip not flagged");
   gpio_change_a: assert property (
      (gpio_select_i[0] && !gpio_dir_out_i[0] && gpio_irq_en[0] &&
       $changed(gpio_line_i[0])) |=> gpio_flag[0] ##1 !periph_n)
      else $error("gpio change not flagged");
   shared_hold_a: assert property (
      (trip_flag && !rd_st) |=> !shared_periph_request_n_o)
      else $error("shared request dropped early");
   flag_read_a: assert property (
      (rd_st && pwm_shutdown_n_i && !wr_swt &&
       !(pwm_period_sync_pulse_i && !sync_prev))
      |=> !sync_flag && !trip_flag)
      else $error("flag read did not clear");
   gpio_read_a: assert property (
      (rd_glo && gpio_set[7:0] == 8'h00) |=> gpio_flag[7:0] == 8'h00)
      else $error("gpio read did not clear");
   mask_gate_a: assert property (
      (core_irq_req_o && core_vector_o == VEC_TRIP)
      |-> $past(interrupt_mask_reg[MASK_PERIPH_BIT]))
      else $error("masked shared request passed");
   sw_only_a: assert property (
      $rose(latched[SRC_SW0]) |-> $past(wr_force && reg_wdata_i[11]))
      else $error("software interrupt without force");
   force_clear_a: assert property (
      (wr_force && reg_wdata_i[SRC_SW0] && !reg_wdata_i[FORCE_BASE + SRC_SW0])
      |=> !latched[SRC_SW0])
      else $error("force/clear did not clear");
   nest_off_a: assert property (
      (core_irq_req_o && !$past(interrupt_sense_nesting_control[SENSE_NEST]))
      |-> $past(in_service) == '0)
      else $error("nested dispatch while nesting off");
   prio_pick_a: assert property (
      (core_irq_req_o && core_vector_o == VEC_TIMER)
      |-> $past(cand) == NCORE'(1 << SRC_TIMER))
      else $error("timer taken over higher source");
   latency_a: assert property (
      (in_service == '0 && interrupt_mask_reg[SRC_TIMER] && timer_expire_i
       && !core_ack_i) |=> ##1 core_irq_req_o)
      else $error("added dispatch latency");
   vec_slot_a: assert property (
      core_irq_req_o |-> core_vector_o <= VEC_TABLE_END &&
                         core_vector_o % VEC_SLOT_WORDS == 0)
      else $error("vector outside a table slot");

   trip_cov_c: cover property (
      core_irq_req_o && core_vector_o == VEC_TRIP ##1 core_ack_i);
   gpio_cov_c: cover property ($rose(gpio_flag[8]));
   nest_cov_c: cover property (
      core_irq_req_o && in_service != '0 && core_ack_i);

endmodule // pic_core

// File: pic_pkg.sv
// Constants for the peripheral interrupt controller
package pic_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam int NGPIO  = 9;
   localparam int NCORE  = 6;

   // Register offsets
   localparam logic [13:0] GPIO_LOW_EN_OFS     = 14'h2006;
   localparam logic [13:0] GPIO_LOW_FLAG_OFS   = 14'h2007;
   localparam logic [13:0] SYNC_TRIP_FLAG_OFS  = 14'h2017;
   localparam logic [13:0] GPIO_NINTH_EN_OFS   = 14'h2046;
   localparam logic [13:0] GPIO_NINTH_FLAG_OFS = 14'h2047;
   localparam logic [13:0] SW_SHUTDOWN_OFS     = 14'h2061;
   localparam logic [13:0] MASK_OFS            = 14'h3F00;
   localparam logic [13:0] FORCE_OFS           = 14'h3F01;
   localparam logic [13:0] SENSE_OFS           = 14'h3F02;
   localparam logic [13:0] CORE_STAT_OFS       = 14'h3F03;

   // Field positions
   localparam int TRIP_FLAG_BIT     = 0;
   localparam int SYNC_FLAG_BIT     = 1;
   localparam int MASK_PERIPH_BIT   = 9;
   localparam int SENSE_RX_EDGE     = 0;
   localparam int SENSE_TX_EDGE     = 1;
   localparam int SENSE_PERIPH_EDGE = 2;
   localparam int SENSE_NEST        = 4;
   localparam int FORCE_BASE        = 8;

   // Core source index: a higher index is a higher priority
   localparam int SRC_TIMER  = 0;
   localparam int SRC_RX     = 1;
   localparam int SRC_TX     = 2;
   localparam int SRC_SW0    = 3;
   localparam int SRC_SW1    = 4;
   localparam int SRC_PERIPH = 5;

   // Vector slots, four words each, table spans 0x0000 to 0x002F
   localparam int          VEC_SLOT_WORDS = 4;
   localparam logic [13:0] VEC_TABLE_END  = 14'h002F;
   localparam logic [13:0] VEC_PERIPH     = 14'h0004;
   localparam logic [13:0] VEC_GPIO       = 14'h0008;
   localparam logic [13:0] VEC_SYNC       = 14'h000C;
   localparam logic [13:0] VEC_SW1        = 14'h0018;
   localparam logic [13:0] VEC_SW0        = 14'h001C;
   localparam logic [13:0] VEC_TX         = 14'h0020;
   localparam logic [13:0] VEC_RX         = 14'h0024;
   localparam logic [13:0] VEC_TIMER      = 14'h0028;
   localparam logic [13:0] VEC_TRIP       = 14'h002C;

   // Reset values
   localparam logic [9:0] MASK_RST    = 10'h000;
   localparam logic [4:0] SENSE_RST   = 5'h00;
   localparam logic [8:0] GPIO_EN_RST = 9'h000;
endpackage

// File: pic_seq_model.sv
// Behavioural core sequencer that takes offered vectors and returns
`timescale 1ns/1ps
module pic_seq_model (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // Offer from the controller
   input  wire logic        irq_req_i,
   input  wire logic [13:0] vector_i,
   // Pacing from the bench
   input  wire logic [3:0]  ack_delay_i,
   input  wire logic        hold_i,
   // Answers
   output logic             ack_o,
   output logic             return_o,
   output logic      [13:0] last_vector_o,
   output logic      [7:0]  ack_count_o
);
   logic [3:0] wait_cnt;
   logic [1:0] open_cnt;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_o         <= 1'b0;
         return_o      <= 1'b0;
         last_vector_o <= '0;
         ack_count_o   <= '0;
         wait_cnt      <= '0;
         open_cnt      <= '0;
      end else begin
         ack_o    <= 1'b0;
         return_o <= 1'b0;
         // Take a vector only while it is still offered
         if (irq_req_i && !ack_o) begin
            if (wait_cnt >= ack_delay_i) begin
               ack_o         <= 1'b1;
               last_vector_o <= vector_i;
               ack_count_o   <= ack_count_o + 8'h01;
               wait_cnt      <= '0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= '0;
         end
         // Handlers end only when the bench lets them, at most one every second cycle
         if (open_cnt != 2'h0 && !hold_i && !return_o) begin
            return_o <= 1'b1;
         end
         open_cnt <= open_cnt + {1'b0, ack_o} - {1'b0, return_o};
      end
   end
endmodule // pic_seq_model

// File: testbench.sv
// Self-checking bench for the peripheral interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   import pic_pkg::*;
   logic              clk, nrst, wr, rd_s, ack, ret, hold, irq, shn;
   logic              tmr, rxn, txn, sync_p, trip_n;
   logic [ADDR_W-1:0] addr, vec, last_vec;
   logic [DATA_W-1:0] wdata, rdata;
   logic [NGPIO-1:0]  gpio, gdir, gsel;
   logic [3:0]        dly;
   logic [7:0]        acks;
   int                errors, comparisons;

   pic_core DUT (
      .sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .core_ack_i(ack),
      .core_return_i(ret), .core_irq_req_o(irq), .core_vector_o(vec),
      .shared_periph_request_n_o(shn), .timer_expire_i(tmr),
      .serial_rx_request_n_i(rxn), .serial_tx_request_n_i(txn),
      .pwm_period_sync_pulse_i(sync_p), .pwm_shutdown_n_i(trip_n),
      .gpio_line_i(gpio), .gpio_select_i(gsel), .gpio_dir_out_i(gdir)
   );

   pic_seq_model SEQ (
      .sys_clk_i(clk), .nrst_i(nrst), .irq_req_i(irq), .vector_i(vec),
      .ack_delay_i(dly), .hold_i(hold), .ack_o(ack), .return_o(ret),
      .last_vector_o(last_vec), .ack_count_o(acks)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [13:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic chk_rd(input logic [13:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask

   // Bounded wait for the sequencer to take a vector
   task automatic expect_vec(input logic [13:0] v);
      logic [7:0] n0;
      n0 = acks;
      for (int i = 0; i < 40 && acks == n0; i++)
         cyc(1);
      if (acks == n0) begin
         errors++;
         $display("[FAIL] %0t no vector taken", $time);
         test_done();
      end
      `CHK(last_vec, v)
   endtask

   task automatic rel;
      @(posedge clk);
      hold <= 1'b0;
      @(posedge clk);
      hold <= 1'b1;
      cyc(1);
   endtask

   task automatic no_req(input int n);
      repeat (n) begin
         cyc(1);
         `CHK(irq, 1'b0)
      end
   endtask

   task automatic t_reset;
      `CHK(shn, 1'b1)
      `CHK(irq, 1'b0)
      chk_rd(GPIO_LOW_EN_OFS, 16'h0000);
      chk_rd(GPIO_NINTH_EN_OFS, 16'h0000);
      chk_rd(MASK_OFS, 16'h0000);
      chk_rd(SENSE_OFS, 16'h0000);
      chk_rd(FORCE_OFS, 16'h0000);
      chk_rd(14'h2000, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_periph;
      @(posedge clk);
      sync_p <= 1'b1;
      @(posedge clk);
      sync_p <= 1'b0;
      cyc(2);
      `CHK(shn, 1'b0)
      no_req(6);
      chk_rd(SYNC_TRIP_FLAG_OFS, 16'h0002);
      `CHK(shn, 1'b1)
      wreg(SENSE_OFS, 16'h0000);
      wreg(MASK_OFS, 16'h0200);
      @(posedge clk);
      trip_n <= 1'b0;
      sync_p <= 1'b1;
      expect_vec(VEC_TRIP);
      chk_rd(SYNC_TRIP_FLAG_OFS, 16'h0003);
      chk_rd(SYNC_TRIP_FLAG_OFS, 16'h0000);
      `CHK(shn, 1'b1)
      rel();
      @(posedge clk);
      trip_n <= 1'b1;
      sync_p <= 1'b0;
      wreg(SW_SHUTDOWN_OFS, 16'h0000);
      expect_vec(VEC_TRIP);
      chk_rd(SYNC_TRIP_FLAG_OFS, 16'h0001);
      rel();
      @(posedge clk);
      sync_p <= 1'b1;
      expect_vec(VEC_SYNC);
      chk_rd(SYNC_TRIP_FLAG_OFS, 16'h0002);
      sync_p <= 1'b0;
      rel();
      $display("test peripheral done");
   endtask

   task automatic t_gpio;
      wreg(GPIO_LOW_EN_OFS, 16'h0003);
      wreg(GPIO_NINTH_EN_OFS, 16'h0001);
      chk_rd(GPIO_LOW_EN_OFS, 16'h0003);
      // Line 1 is an output, so only lines 0 and 8 count
      @(posedge clk);
      gpio <= 9'h103;
      expect_vec(VEC_GPIO);
      chk_rd(GPIO_LOW_FLAG_OFS, 16'h0001);
      `CHK(shn, 1'b0)
      chk_rd(GPIO_NINTH_FLAG_OFS, 16'h0001);
      `CHK(shn, 1'b1)
      rel();
      @(posedge clk);
      gpio <= 9'h000;
      expect_vec(VEC_GPIO);
      chk_rd(GPIO_LOW_FLAG_OFS, 16'h0001);
      chk_rd(GPIO_NINTH_FLAG_OFS, 16'h0001);
      rel();
      @(posedge clk);
      // Line 2 not enabled, line 0 no longer selected for I/O
      gpio <= 9'h005;
      gsel <= 9'h1FE;
      cyc(4);
      `CHK(shn, 1'b1)
      $display("test gpio done");
   endtask

   task automatic t_core;
      wreg(MASK_OFS, 16'h0000);
      wreg(FORCE_OFS, 16'h1900);
      chk_rd(CORE_STAT_OFS, 16'h0019);
      wreg(FORCE_OFS, 16'h0009);
      chk_rd(CORE_STAT_OFS, 16'h0010);
      wreg(FORCE_OFS, 16'h0900);
      wreg(MASK_OFS, 16'h0019);
      expect_vec(VEC_SW1);
      no_req(5);
      rel();
      expect_vec(VEC_SW0);
      rel();
      expect_vec(VEC_TIMER);
      rel();
      // Prompt answers, and a higher source nests over the timer
      wreg(SENSE_OFS, 16'h0010);
      dly <= 4'h0;
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
      expect_vec(VEC_TIMER);
      wreg(FORCE_OFS, 16'h1000);
      expect_vec(VEC_SW1);
      rel();
      rel();
      chk_rd(CORE_STAT_OFS, 16'h0000);
      $display("test core done");
   endtask

   task automatic t_serial;
      dly <= 4'h3;
      wreg(SENSE_OFS, 16'h0001);
      wreg(MASK_OFS, 16'h0006);
      @(posedge clk);
      rxn <= 1'b0;
      txn <= 1'b0;
      expect_vec(VEC_TX);
      @(posedge clk);
      rxn <= 1'b1;
      txn <= 1'b1;
      rel();
      // Edge on receive stays latched; level on transmit has gone
      expect_vec(VEC_RX);
      rel();
      no_req(6);
      // Receive level, transmit edge: a low transmit line is taken once
      wreg(SENSE_OFS, 16'h0002);
      @(posedge clk);
      rxn <= 1'b0;
      txn <= 1'b0;
      expect_vec(VEC_TX);
      rel();
      expect_vec(VEC_RX);
      @(posedge clk);
      rxn <= 1'b1;
      rel();
      no_req(6);
      @(posedge clk);
      txn <= 1'b1;
      $display("test serial done");
   endtask

   initial begin
      nrst = 1'b0;
      {wr, rd_s, tmr, sync_p} = '0;
      {hold, rxn, txn, trip_n} = 4'hF;
      addr = '0;
      wdata = '0;
      gpio = '0;
      gdir = 9'h002;
      gsel = 9'h1FF;
      dly = 4'h3;
      errors = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      cyc(1);
      t_reset();
      t_periph();
      t_gpio();
      t_core();
      t_serial();
      // A reset in mid-run clears what software set up
      wreg(GPIO_LOW_EN_OFS, 16'h00FF);
      @(posedge clk);
      nrst <= 1'b0;
      cyc(5);
      nrst <= 1'b1;
      cyc(1);
      t_reset();
      test_done();
   end
endmodule // testbench
